// ---- include/ppt_cfg.svh ----
`ifndef PPT_CFG_SVH
`define PPT_CFG_SVH

// Clocks from a driven value to its parity bit
`define PPT_PAR_LAG 1
// Clocks from received data to the data parity error strobe
`define PPT_PERR_LAG 2
// Clocks a sustained signal is driven inactive before release
`define PPT_TAIL_CYC 1

// Values parked on the bus while idle and granted
`define PPT_PARK_AD 32'h0000_0000
`define PPT_PARK_CBE_N 4'h0

// Reset values of pin drives
`define PPT_REQ_N_RST 1'b1
`define PPT_PIN_N_RST 1'b1

`endif

// ---- include/ppt_pkg.sv ----
package ppt_pkg;

    // Address/data lines with their command/byte enables
    typedef struct packed
    {
        logic [31:0] ad;
        logic [3:0] cbe_n;
    } adcbe_t;

    // Bridge events that may raise system error
    typedef struct packed
    {
        logic sec_pw_perr;
        logic pw_mabort;
        logic pw_tabort;
        logic pw_discard;
        logic dw_discard;
        logic dr_discard;
        logic dt_mtimeout;
        logic sec_serr;
    } serr_evt_t;

    // Target termination seen by us as initiator
    typedef struct packed
    {
        logic disc_data;
        logic disc_nodata;
        logic retry;
        logic tabort;
    } term_t;

    // Primary bus activity
    typedef enum logic
    {
        BUS_IDLE,
        BUS_DATA
    } bus_state_t;

    // Even parity over 36 bits: ones plus parity come out even
    function automatic logic even_par(input adcbe_t v);
        even_par = ^v;
    endfunction

endpackage

// ---- core/sts_drv.sv ----
`include "ppt_cfg.svh"

// Sustained tristate pin driver: drives while on, then high one clock
module sts_drv
(
    // Clock and reset
    input logic i_clk,
    input logic i_rst,
    // Control from the owning block
    input logic i_on,
    input logic i_assert,
    // Pin drive, active low level with enable
    output logic o_n,
    output logic o_oe
);
    import ppt_pkg::*;

    logic tail_r;

    ////////////////////////////////////////////////////////////////////
    // Drive, then one inactive clock, then let the pull-up hold it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_n <= `PPT_PIN_N_RST;
            o_oe <= 1'b0;
            tail_r <= 1'b0;
        end
        else if (i_on)
        begin
            o_n <= ~i_assert;
            o_oe <= 1'b1;
            tail_r <= 1'b1;
        end
        else if (tail_r)
        begin
            // Actively high so the bus never floats from low
            o_n <= 1'b1;
            o_oe <= 1'b1;
            tail_r <= 1'b0;
        end
        else
        begin
            o_n <= 1'b1;
            o_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_tail_inactive: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(i_on) |=> o_oe && o_n)
        else $error("sustained pin not driven high after end");

    a_tail_release: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(i_on) ##1 !i_on |=> !o_oe)
        else $error("sustained pin not released after one clock");

endmodule // sts_drv

// ---- core/ppt_primary.sv ----
`include "ppt_cfg.svh"

// What this block does
// - Parity is even over 36 AD/CBE bits
// - Driver of address or data drives parity
// - Parity valid one clock after its data
// - Parity released one clock after AD released
// - Receiver checks parity against received data
// - Idle, granted, not requesting: park, parity one later
// - Receiver asserts data parity error on mismatch
// - Parity error two clocks after data
// - Target reports on writes, initiator on reads
// - Sustained signals driven high one clock, released
// - Request asserted while wanting the bus
// - System error on address or secondary parity
// - System error on posted write aborts, discards
// - System error on delayed discards, timeouts, secondary
// - Stop with ready and select: disconnect with data
// - Stop and select, not ready: disconnect, no data
// - No-data disconnect on first phase is retry
// - Stop without select is target abort
// - Target ready means accept or data valid
// - Target ready held until phase completes or abort
// - Initiator ready marks write data valid
module ppt_primary
(
    // Clock and reset
    input logic i_clk,
    input logic i_rst,
    // Primary bus pins as sampled
    input ppt_pkg::adcbe_t i_bus,
    input logic i_par,
    input logic i_frame_n,
    input logic i_irdy_n,
    input logic i_trdy_n,
    input logic i_devsel_n,
    input logic i_stop_n,
    input logic i_gnt_n,
    // Primary bus pin drives
    output ppt_pkg::adcbe_t o_bus,
    output logic o_bus_oe,
    output logic o_par,
    output logic o_par_oe,
    output logic o_perr_n,
    output logic o_perr_oe,
    output logic o_trdy_n,
    output logic o_trdy_oe,
    output logic o_stop_n,
    output logic o_stop_oe,
    output logic o_devsel_n,
    output logic o_devsel_oe,
    output logic o_serr_n,
    output logic o_serr_oe,
    output logic o_req_n,
    // Initiator side of the core
    input logic i_want_bus,
    input logic i_drive,
    input ppt_pkg::adcbe_t i_drive_val,
    input logic i_mst_active,
    input logic i_mst_read,
    output ppt_pkg::term_t o_term,
    // Target side of the core
    input logic i_tgt_on,
    input logic i_tgt_write,
    input logic i_tgt_ready,
    input logic i_tgt_stop,
    input logic i_tgt_abort,
    // Error enables, events and status
    input logic i_perr_en,
    input logic i_serr_en,
    input ppt_pkg::serr_evt_t i_serr_evt,
    output logic o_data_perr,
    output logic o_addr_perr
);
    import ppt_pkg::*;

    bus_state_t state_r;
    logic addr_phase;
    logic bus_idle;
    logic park;
    logic xfer;
    logic rx;
    logic rx_r;
    adcbe_t rx_val_r;
    logic rx_par_bad;
    logic addr_r;
    logic addr_hit;
    logic moved_r;
    logic mst_data;
    logic trdy_hold;
    logic trdy_assert;
    logic disc;
    term_t term_nxt;

    ////////////////////////////////////////////////////////////////////
    // Bus activity tracking from the sampled framing signals
    assign addr_phase = (state_r == BUS_IDLE) && !i_frame_n;
    assign bus_idle = (state_r == BUS_IDLE) && i_frame_n && i_irdy_n;
    // A data phase completes when both ready signals are low
    assign xfer = (state_r == BUS_DATA) && !i_irdy_n && !i_trdy_n;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_r <= BUS_IDLE;
        end
        else
        begin
            case (state_r)
                BUS_IDLE:
                begin
                    if (!i_frame_n)
                    begin
                        state_r <= BUS_DATA;
                    end
                end
                BUS_DATA:
                begin
                    if (i_frame_n && i_irdy_n)
                    begin
                        state_r <= BUS_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address/data drive, core value or parked value
    // Parking only when not requesting; a request means the core drives
    assign park = bus_idle && !i_gnt_n && !i_want_bus;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_bus <= '0;
            o_bus_oe <= 1'b0;
        end
        else if (i_drive)
        begin
            o_bus <= i_drive_val;
            o_bus_oe <= 1'b1;
        end
        else if (park)
        begin
            o_bus.ad <= `PPT_PARK_AD;
            o_bus.cbe_n <= `PPT_PARK_CBE_N;
            o_bus_oe <= 1'b1;
        end
        else
        begin
            o_bus_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Parity follows whatever we drove one clock earlier, so address,
    // write data, read data and parked values all get it for free
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_par <= 1'b0;
            o_par_oe <= 1'b0;
        end
        else
        begin
            o_par <= even_par(o_bus);
            o_par_oe <= o_bus_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data receive check: we receive on target writes and our reads
    // Write data is valid with initiator ready, read data with target ready
    assign rx = xfer && ((i_tgt_on && i_tgt_write) || (i_mst_active && i_mst_read));
    assign rx_par_bad = rx_r && (even_par(rx_val_r) != i_par);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rx_r <= 1'b0;
            rx_val_r <= '0;
            addr_r <= 1'b0;
        end
        else
        begin
            rx_r <= rx;
            rx_val_r <= i_bus;
            addr_r <= addr_phase;
        end
    end

    // Parity error strobe lands one clock after parity, two after data
    sts_drv u_perr
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_on(rx_r),
        .i_assert(rx_par_bad && i_perr_en),
        .o_n(o_perr_n),
        .o_oe(o_perr_oe)
    );

    ////////////////////////////////////////////////////////////////////
    // Address parity check, every agent watches every address
    // The bus sample is shared with the data check above
    assign addr_hit = addr_r && (even_par(rx_val_r) != i_par);

    ////////////////////////////////////////////////////////////////////
    // System error, open drain: only ever pulled low, one clock pulse
    assign o_serr_n = 1'b0;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_serr_oe <= 1'b0;
            o_data_perr <= 1'b0;
            o_addr_perr <= 1'b0;
            o_req_n <= `PPT_REQ_N_RST;
        end
        else
        begin
            o_serr_oe <= i_serr_en && (addr_hit || (|i_serr_evt));
            // Status pulses report errors even when pin reporting is disabled
            o_data_perr <= rx_par_bad;
            o_addr_perr <= addr_hit;
            o_req_n <= ~i_want_bus; // Arbiter request
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Termination decode while we are the initiator
    assign mst_data = i_mst_active && (state_r == BUS_DATA);

    // Remembers whether any data moved, to tell retry from disconnect
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            moved_r <= 1'b0;
        end
        else if (addr_phase)
        begin
            moved_r <= 1'b0;
        end
        else if (xfer)
        begin
            moved_r <= 1'b1;
        end
    end

    // One bit at most: abort beats data, and retry needs no data moved yet
    assign disc = mst_data && !i_stop_n && !i_devsel_n;
    assign term_nxt.tabort = mst_data && !i_stop_n && i_devsel_n;
    assign term_nxt.disc_data = disc && !i_trdy_n;
    assign term_nxt.disc_nodata = disc && i_trdy_n && moved_r;
    assign term_nxt.retry = disc && i_trdy_n && !moved_r;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_term <= '0;
        end
        else
        begin
            o_term <= term_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Target response pins; abort drops select and raises stop
    // Ready, once shown, stays until the initiator completes the phase or target abort drops it
    assign trdy_hold = o_trdy_oe && !o_trdy_n && i_irdy_n;
    assign trdy_assert = !i_tgt_abort && (i_tgt_ready || trdy_hold);

    sts_drv u_trdy
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_on(i_tgt_on),
        .i_assert(trdy_assert),
        .o_n(o_trdy_n),
        .o_oe(o_trdy_oe)
    );

    sts_drv u_stop
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_on(i_tgt_on),
        .i_assert(i_tgt_stop || i_tgt_abort),
        .o_n(o_stop_n),
        .o_oe(o_stop_oe)
    );

    sts_drv u_devsel
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_on(i_tgt_on),
        .i_assert(!i_tgt_abort),
        .o_n(o_devsel_n),
        .o_oe(o_devsel_oe)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_par_follows_ad: assert property (@(posedge i_clk) disable iff (i_rst)
        o_bus_oe |=> o_par_oe && (o_par == ^$past(o_bus)))
        else $error("parity not valid one clock after drive");

    a_par_release: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_bus_oe) |-> o_par_oe ##1 !o_par_oe)
        else $error("parity not released one clock after lines");

    a_park_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        park && !i_drive |=> o_bus_oe && o_bus.ad == `PPT_PARK_AD ##1 o_par_oe)
        else $error("idle granted bus not parked with parity");

    a_perr_timing: assert property (@(posedge i_clk) disable iff (i_rst)
        rx ##1 (rx_par_bad && i_perr_en) |=> o_perr_oe && !o_perr_n)
        else $error("parity error not two clocks after data");

    a_perr_cause: assert property (@(posedge i_clk) disable iff (i_rst)
        o_perr_oe && !o_perr_n |-> $past(rx, 2) && $past(i_perr_en))
        else $error("parity error without received data");

    a_req_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        i_want_bus |=> !o_req_n)
        else $error("request not asserted while bus wanted");

    a_serr_addr: assert property (@(posedge i_clk) disable iff (i_rst)
        addr_phase ##1 (i_par != ^$past(i_bus)) && i_serr_en |=> o_serr_oe)
        else $error("address parity error did not raise system error");

    a_serr_event: assert property (@(posedge i_clk) disable iff (i_rst)
        (|i_serr_evt) && i_serr_en |=> o_serr_oe)
        else $error("bridge event did not raise system error");

    a_serr_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_serr_en |=> !o_serr_oe)
        else $error("system error raised while disabled");

    a_term_retry: assert property (@(posedge i_clk) disable iff (i_rst)
        mst_data && !i_stop_n && !i_devsel_n && i_trdy_n && !moved_r |=> o_term.retry)
        else $error("first phase no-data disconnect not a retry");

    a_term_abort: assert property (@(posedge i_clk) disable iff (i_rst)
        mst_data && !i_stop_n && i_devsel_n |=> o_term.tabort && !o_term.retry)
        else $error("stop without select not decoded as abort");

    a_trdy_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        trdy_hold && i_tgt_on && !i_tgt_abort |=> !o_trdy_n)
        else $error("target ready dropped before phase completed");

endmodule // ppt_primary

// ---- bench/pci_agent_model.sv ----
// Far side of the primary bus: other agents, arbiter grant and pull-ups
module pci_agent_model
(
    // Clock
    input logic i_clk,
    // Bench commands, active high
    input logic i_frame,
    input logic i_irdy,
    input logic i_trdy,
    input logic i_devsel,
    input logic i_stop,
    input logic i_gnt,
    input logic i_drive,
    input ppt_pkg::adcbe_t i_val,
    input logic i_bad_par,
    // Device pin drives, sustained pins as {perr, trdy, stop, devsel, serr}
    input ppt_pkg::adcbe_t i_dut_bus,
    input logic i_dut_bus_oe,
    input logic i_dut_par,
    input logic i_dut_par_oe,
    input logic [4:0] i_dut_n,
    input logic [4:0] i_dut_oe,
    // Resolved wires
    output ppt_pkg::adcbe_t o_bus,
    output logic o_par,
    output logic o_frame_n,
    output logic o_irdy_n,
    output logic o_gnt_n,
    output logic [4:0] o_sts_n
);
    import ppt_pkg::*;

    logic par_r = 1'b0;
    logic par_oe_r = 1'b0;
    logic last_par_r = 1'b0;
    adcbe_t last_r = '0;
    logic [4:0] own_n;

    ////////////////////////////////////////////////////////////////////////////
    // Our parity trails our data by one clock and lets go one clock later
    always_ff @(posedge i_clk)
    begin
        par_r <= (^i_val) ^ i_bad_par;
        par_oe_r <= i_drive;
        last_r <= o_bus;
        last_par_r <= o_par;
    end

    ////////////////////////////////////////////////////////////////////////////
    // No pull-up on AD or parity: a released line shows the inverse of its last value,
    // so a stale sample can never look right by chance
    assign o_bus = i_dut_bus_oe ? i_dut_bus : (i_drive ? i_val : ~last_r);
    assign o_par = i_dut_par_oe ? i_dut_par : (par_oe_r ? par_r : ~last_par_r);
    // Sustained pins fall back to the far-side drive, else the pull-up level
    assign own_n = ~{1'b0, i_trdy, i_stop, i_devsel, 1'b0};
    assign o_sts_n = (i_dut_oe & i_dut_n) | (~i_dut_oe & own_n);
    assign o_frame_n = ~i_frame;
    assign o_irdy_n = ~i_irdy;
    assign o_gnt_n = ~i_gnt;
endmodule // pci_agent_model

// ---- bench/test_pci_primary_parity_termination.sv ----
module test_pci_primary_parity_termination;
    timeunit 1ns;
    timeprecision 1ps;
    import ppt_pkg::*;

    logic i_clk = 1'b0, i_rst = 1'b1;
    // Far-side commands
    logic c_frame = 0, c_irdy = 0, c_trdy = 0, c_devsel = 0, c_stop = 0, c_gnt = 0;
    logic c_drive = 0, c_bad = 0;
    adcbe_t c_val = '0;
    // Core-side inputs
    logic i_want_bus = 0, i_drive = 0, i_mst_active = 0, i_mst_read = 0;
    logic i_tgt_on = 0, i_tgt_write = 0, i_tgt_ready = 0, i_tgt_stop = 0, i_tgt_abort = 0;
    logic i_perr_en = 0, i_serr_en = 0;
    adcbe_t i_drive_val = '0;
    serr_evt_t i_serr_evt = '0;
    // Wires and device outputs
    adcbe_t w_bus, o_bus;
    logic w_par, w_frame_n, w_irdy_n, w_gnt_n;
    logic [4:0] w_sts_n;
    logic o_bus_oe, o_par, o_par_oe, o_perr_n, o_perr_oe, o_trdy_n, o_trdy_oe, o_stop_n;
    logic o_stop_oe, o_devsel_n, o_devsel_oe, o_serr_n, o_serr_oe, o_req_n;
    logic o_data_perr, o_addr_perr;
    term_t o_term;
    int fail_count = 0, n_compared = 0, cycles = 0;

    ppt_primary u_dut
    (
        .i_clk, .i_rst, .i_bus(w_bus), .i_par(w_par), .i_frame_n(w_frame_n),
        .i_irdy_n(w_irdy_n), .i_trdy_n(w_sts_n[3]), .i_devsel_n(w_sts_n[1]),
        .i_stop_n(w_sts_n[2]), .i_gnt_n(w_gnt_n), .o_bus, .o_bus_oe, .o_par, .o_par_oe,
        .o_perr_n, .o_perr_oe, .o_trdy_n, .o_trdy_oe, .o_stop_n, .o_stop_oe, .o_devsel_n,
        .o_devsel_oe, .o_serr_n, .o_serr_oe, .o_req_n, .i_want_bus, .i_drive, .i_drive_val,
        .i_mst_active, .i_mst_read, .o_term, .i_tgt_on, .i_tgt_write, .i_tgt_ready,
        .i_tgt_stop, .i_tgt_abort, .i_perr_en, .i_serr_en, .i_serr_evt, .o_data_perr,
        .o_addr_perr
    );

    pci_agent_model u_far
    (
        .i_clk, .i_frame(c_frame), .i_irdy(c_irdy), .i_trdy(c_trdy), .i_devsel(c_devsel),
        .i_stop(c_stop), .i_gnt(c_gnt), .i_drive(c_drive), .i_val(c_val), .i_bad_par(c_bad),
        .i_dut_bus(o_bus), .i_dut_bus_oe(o_bus_oe), .i_dut_par(o_par), .i_dut_par_oe(o_par_oe),
        .i_dut_n({o_perr_n, o_trdy_n, o_stop_n, o_devsel_n, o_serr_n}),
        .i_dut_oe({o_perr_oe, o_trdy_oe, o_stop_oe, o_devsel_oe, o_serr_oe}),
        .o_bus(w_bus), .o_par(w_par), .o_frame_n(w_frame_n), .o_irdy_n(w_irdy_n),
        .o_gnt_n(w_gnt_n), .o_sts_n(w_sts_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling well above the roughly 75 the tests need
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Inputs change at the falling edge, so each check sees settled outputs
    task automatic step();
        @(negedge i_clk);
    endtask

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Back-to-back drives: parity trails each value, then lets go
    task automatic t_drive();
        adcbe_t v1 = '{ad: 32'h0000_0001, cbe_n: 4'h0};
        adcbe_t v2 = '{ad: 32'h8000_0001, cbe_n: 4'h3};
        i_drive = 1;
        i_drive_val = v1;
        step();
        chk("bus", {o_bus_oe, o_bus}, {1'b1, v1});
        i_drive_val = v2;
        step();
        chk("bus", o_bus, v2);
        chk("par", {o_par_oe, o_par}, {1'b1, ^v1});
        i_drive = 0;
        step();
        chk("par", {o_bus_oe, o_par_oe, w_par}, {2'b01, ^v2});
        step();
        chk("par_oe", o_par_oe, 1'b0);
        $display("t_drive done");
    endtask

    // Parking while granted, then request
    task automatic t_park();
        c_gnt = 1;
        step();
        chk("park", {o_bus_oe, o_par_oe, o_bus}, {2'b10, 36'h0});
        step();
        chk("park_par", {o_par_oe, o_par}, 2'b10);
        c_gnt = 0;
        i_want_bus = 1;
        step();
        chk("req", o_req_n, 1'b0);
        i_want_bus = 0;
        step();
        chk("req", o_req_n, 1'b1);
        step();
        $display("t_park done");
    endtask

    // Received data, as target of a write or initiator of a read, optionally bad parity
    task automatic t_rx(input logic bad, input logic en, input logic rd);
        i_perr_en = en;
        {i_tgt_on, i_tgt_write, i_tgt_ready} = {!rd, 2'b11};
        {i_mst_active, i_mst_read} = {rd, rd};
        {c_frame, c_drive} = 2'b11;
        c_val = '{ad: 32'h1234_5678, cbe_n: 4'h7};
        step();
        {c_frame, c_irdy, c_bad, c_trdy, c_devsel} = {2'b01, bad, rd, rd};
        c_val = '{ad: 32'hcafe_0f0f, cbe_n: 4'h0};
        step();
        {c_irdy, c_drive, c_bad, i_tgt_on, c_trdy, c_devsel} = 6'b000000;
        {i_mst_active, i_mst_read} = 2'b00;
        step();
        chk("perr_n", o_perr_n, !(bad && en));
        chk("data_perr", o_data_perr, bad);
        step();
        if (bad && en)
            chk("perr_tail", {o_perr_oe, o_perr_n}, 2'b11);
        step();
        chk("perr_oe", o_perr_oe, 1'b0);
        $display("t_rx done");
    endtask

    // Address parity error and every bridge event raise system error
    task automatic t_serr();
        i_serr_en = 1;
        {c_frame, c_drive, c_bad} = 3'b111;
        c_val = '{ad: 32'h0000_00ff, cbe_n: 4'h1};
        step();
        {c_frame, c_drive, c_bad} = 3'b000;
        step();
        chk("addr_serr", {o_serr_oe, o_addr_perr, w_sts_n[0]}, 3'b110);
        step();
        chk("serr_end", o_serr_oe, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            i_serr_en = (i < 8);
            i_serr_evt = serr_evt_t'(8'h01 << (i % 8));
            step();
            i_serr_evt = '0;
            chk("evt_serr", o_serr_oe, i < 8);
            step();
        end
        $display("t_serr done");
    endtask

    // Each of the four terminations seen as initiator, as stop with {data first, devsel, trdy}
    task automatic t_term();
        logic [2:0] cs [4] = '{3'b010, 3'b110, 3'b011, 3'b000};
        term_t ex [4] = '{4'b0010, 4'b0100, 4'b1000, 4'b0001};
        i_mst_active = 1;
        for (int i = 0; i < 4; i++)
        begin
            c_frame = 1;
            step();
            {c_irdy, c_devsel, c_trdy} = {2'b11, cs[i][2]};
            if (cs[i][2])
                step();
            {c_devsel, c_trdy, c_stop} = {cs[i][1:0], 1'b1};
            step();
            chk("term", o_term, ex[i]);
            {c_frame, c_irdy, c_devsel, c_trdy, c_stop} = 5'b00000;
            step();
        end
        i_mst_active = 0;
        $display("t_term done");
    endtask

    // Our target pins: ready, hold, stop, abort, then tail and release
    task automatic t_tgt();
        {i_tgt_on, i_tgt_ready} = 2'b11;
        step();
        chk("tgt_go", {o_devsel_n, o_trdy_n, o_stop_n, o_trdy_oe}, 4'b0011);
        i_tgt_ready = 0;
        step();
        chk("trdy_hold", o_trdy_n, 1'b0);
        c_irdy = 1;
        step();
        chk("trdy_done", o_trdy_n, 1'b1);
        {c_irdy, i_tgt_stop} = 2'b01;
        step();
        chk("stop", {o_devsel_n, o_trdy_n, o_stop_n}, 3'b010);
        i_tgt_abort = 1;
        step();
        chk("abort", {o_devsel_n, o_trdy_n, o_stop_n}, 3'b110);
        {i_tgt_on, i_tgt_stop, i_tgt_abort} = 3'b000;
        step();
        chk("tail", {o_devsel_n, o_trdy_n, o_stop_n, o_devsel_oe, o_trdy_oe, o_stop_oe},
            6'b111111);
        step();
        chk("release", {o_devsel_oe, o_trdy_oe, o_stop_oe}, 3'b000);
        $display("t_tgt done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge i_clk);
        i_rst = 0;
        chk("rst_pins", {o_bus_oe, o_par_oe, o_perr_oe, o_trdy_oe, o_req_n, o_term}, 9'h010);
        t_drive();
        t_park();
        t_rx(1, 1, 0);
        t_rx(0, 1, 0);
        t_rx(1, 0, 0);
        t_rx(1, 1, 1);
        t_serr();
        t_term();
        t_tgt();
        results();
    end
endmodule // test_pci_primary_parity_termination
